// ==== bench/udcc_host_model.sv ====
// Purpose: host side of the bus, drives receive line states
// Assumes: levels after the transceiver; J is dp high, dm low
// Notes:   a state holds until the next call, so se0 can be observed
`timescale 1ns/1ns
module udcc_host_model (
  input  wire logic i_clk_sys, // system clock
  output logic      o_dp,      // d+ level
  output logic      o_dm       // d- level
);
  // pull-up side makes an undriven bus read as idle J
  initial begin
    o_dp = 1'b1;
    o_dm = 1'b0;
  end
  task automatic line(input logic [1:0] st, input int n);
    @(negedge i_clk_sys);
    {o_dp, o_dm} = st;
    repeat (n) @(negedge i_clk_sys);
  endtask : line
endmodule : udcc_host_model

// ==== bench/usb_device_common_control_test.sv ====
// Purpose: self checking bench for the usb common control block
// Assumes: suspend and reset counts shortened through parameters
// Notes:   random fields come from a fixed seed
`timescale 1ns/1ns
module usb_device_common_control_test;
  logic        clk = 1'b0, nrst = 1'b0, dp, dm, wr, rd, sof, appl, gie;
  logic        rle, wle, dwr, ofv, ifw, drv, ures, iso, dres, susp, wake;
  logic        cset, irq;
  logic [15:0] addr, dwd, ofd, ifd, drd, dv;
  logic [7:0]  wdat, rdat;
  logic [5:0]  inev, ev;
  logic [5:1]  outev;
  logic [6:0]  fa, a7;
  logic [3:0]  epi;
  int          seed = 46139, error_cnt = 0, tests_run = 0, irq_cnt = 0, n0;
  int          n1, cset_cnt = 0, wake_cnt = 0, ures_cnt = 0;

  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (cset === 1'b1) cset_cnt <= cset_cnt + 1;
    if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
    if (ures === 1'b1) ures_cnt <= ures_cnt + 1;
  end

  udcc_host_model host (.i_clk_sys(clk), .o_dp(dp), .o_dm(dm));
  udcc_common_ctrl #(.SUSPEND_CYCLES(40), .RESET_CYCLES(4)) dut (
    .i_clk_sys(clk), .i_nrst(nrst), .i_dp(dp), .i_dm(dm),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdat),
    .o_reg_rdata(rdat), .i_sof_token(sof), .i_in_ep_event(inev),
    .i_out_ep_event(outev), .i_addr_applied(appl), .i_cpu_usb_irq_en(gie),
    .i_fifo_read_little(rle), .i_fifo_write_little(wle), .i_dma_wr(dwr),
    .i_dma_wdata(dwd), .o_in_fifo_wr(ifw), .o_in_fifo_data(ifd),
    .i_out_fifo_valid(ofv), .i_out_fifo_data(ofd), .o_dma_rvalid(drv),
    .o_dma_rdata(drd), .o_function_address(fa), .o_endpoint_index(epi),
    .o_usb_reset(ures), .o_iso_wait_sof(iso), .o_drive_resume(dres),
    .o_suspended(susp), .o_wake(wake), .o_cpu_usb_irq_set(cset),
    .o_irq_req(irq));

  function automatic logic [15:0] swap(input logic [15:0] d);
    return {d[7:0], d[15:8]};
  endfunction : swap
  function automatic logic [7:0] out_exp(input logic [5:1] e);
    return {2'b00, e, 1'b0};
  endfunction : out_exp

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdat = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wreg
  task automatic rreg(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk({8'h00, rdat}, {8'h00, e});
  endtask : rreg
  task automatic pulse(input logic [5:0] i, input logic [5:1] o,
                       input logic s);
    @(negedge clk);
    {inev, outev, sof} = {i, o, s};
    @(negedge clk);
    {inev, outev, sof} = 12'h000;
  endtask : pulse
  task automatic summarize;
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    summarize();
  end

  initial begin
    {wr, rd, sof, appl, gie, rle, wle, dwr, ofv} = 9'h000;
    {addr, dwd, ofd, wdat, inev, outev} = 67'h0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    rreg(16'hde07, 8'h3f);
    rreg(16'hde0b, 8'h06);
    rreg(16'hde30, 8'h00);
    $display("test reset_values done");
    a7 = 7'($random(seed));
    wreg(16'hde00, {1'b1, a7});
    rreg(16'hde00, {1'b1, a7});
    @(negedge clk) appl = 1'b1;
    @(negedge clk) appl = 1'b0;
    chk({9'h000, fa}, {9'h000, a7});
    rreg(16'hde00, {1'b0, a7});
    $display("test address done");
    wreg(16'hde0e, 8'h03);
    chk({12'h000, epi}, 16'h0003);
    wreg(16'hde0b, 8'h09);
    n0 = ures_cnt;
    host.line(2'b00, 12);
    chk({15'h0000, ures_cnt == n0 + 1}, 16'h0001);
    rreg(16'hde01, 8'h08);
    host.line(2'b10, 6);
    rreg(16'hde06, 8'h04);
    chk({9'h000, fa}, 16'h0000);
    rreg(16'hde0e, 8'h00);
    rreg(16'hde0b, 8'h06);
    $display("test bus_reset done");
    gie = 1'b1;
    for (int k = 0; k < 4; k++) begin
      ev = 6'($random(seed));
      n0 = irq_cnt;
      n1 = cset_cnt;
      pulse(ev | 6'h01, ev[5:1], 1'b0);
      rreg(16'hde02, {2'b00, ev | 6'h01});
      rreg(16'hde02, 8'h00);
      rreg(16'hde04, out_exp(ev[5:1]));
      chk({15'h0000, irq_cnt != n0}, 16'h0001);
      chk({15'h0000, cset_cnt != n1}, 16'h0001);
    end
    wreg(16'hde07, 8'h00);
    n0 = irq_cnt;
    n1 = cset_cnt;
    pulse(6'h04, 5'h00, 1'b1);
    repeat (3) @(negedge clk);
    chk({15'h0000, irq_cnt == n0}, 16'h0001);
    chk({15'h0000, cset_cnt == n1}, 16'h0001);
    rreg(16'hde02, 8'h04);
    rreg(16'hde06, 8'h08);
    $display("test flags done");
    wreg(16'hde01, 8'h01);
    repeat (60) @(negedge clk);
    chk({15'h0000, susp}, 16'h0001);
    rreg(16'hde01, 8'h03);
    rreg(16'hde06, 8'h01);
    rreg(16'hde01, 8'h01);
    n0 = wake_cnt;
    host.line(2'b01, 8);
    host.line(2'b10, 6);
    chk({15'h0000, susp}, 16'h0000);
    chk({15'h0000, wake_cnt == n0 + 1}, 16'h0001);
    rreg(16'hde06, 8'h02);
    wreg(16'hde01, 8'h04);
    chk({15'h0000, dres}, 16'h0001);
    wreg(16'hde01, 8'h00);
    wreg(16'hde01, 8'h81);
    chk({15'h0000, iso}, 16'h0001);
    repeat (50) @(negedge clk);
    chk({15'h0000, susp}, 16'h0001);
    n0 = wake_cnt;
    host.line(2'b00, 12);
    chk({15'h0000, susp}, 16'h0000);
    chk({15'h0000, wake_cnt == n0 + 1}, 16'h0001);
    host.line(2'b10, 6);
    rreg(16'hde06, 8'h05);
    wreg(16'hde01, 8'h00);
    $display("test suspend done");
    dv = 16'($random(seed));
    for (int m = 0; m < 2; m++) begin
      @(negedge clk);
      {wle, rle, dwr, ofv, dwd, ofd} = {m[0], m[0], 2'b11, dv, ~dv};
      @(negedge clk);
      {dwr, ofv} = 2'b00;
      chk(ifd, m[0] ? dv : swap(dv));
      chk(drd, m[0] ? ~dv : swap(~dv));
      chk({15'h0000, ifw & drv}, 16'h0001);
    end
    $display("test dma done");
    summarize();
  end
endmodule : usb_device_common_control_test

// ==== src/udcc_common_ctrl.sv ====
// Purpose: common control of a full speed usb device controller
// Assumes: endpoint logic shares i_clk_sys; bus pins are asynchronous
// Notes:   indexed endpoint and fifo registers live in the endpoint logic
// Behaviour
// - no hardware dma request outputs; firmware starts every transfer
// - 8 or 16 bit fifo words; global read and write byte order bits
// - bus reset sets reset flag, cpu flag if enabled, then request
// - bus reset enables every interrupt except frame start and suspend
// - after bus reset the device answers address zero only
// - 3 ms unbroken idle with detection on enters suspend, sets flag
// - suspend sets cpu flag if enabled; request needs global enable
// - k state signaling in suspend sets resume flag, wakes, requests
// - bus reset in suspend wakes, requests, sets reset not resume flag
// - resume bit drives resume upstream; software holds 1 to 15 ms
// - registers occupy 0xde00 to 0xde3f; 0xde2c upward is reserved
// - indexed registers follow the selected endpoint index
// - address in bits 6:0; bit 7 set on write, cleared when applied
// - wait for frame bit holds iso in endpoints until next frame start
// - power bit 3 reads one while reset signaling is on the bus
// - power bit 1 shows suspend; cleared by flag read or resume bit
// - in flags: bits 5:1 endpoints, bit 0 control; clear on read
// - out flags: bits 5:1 endpoints, others unused; clear on read
// - common flags: frame, reset, resume, suspend; clear on read
// - endpoint flags set always; cpu flag only when mask bit is one
`timescale 1ns/1ns
module udcc_common_ctrl #(
  parameter int SUSPEND_CYCLES = udcc_pkg::SUSPEND_CYCLES,
  parameter int RESET_CYCLES   = udcc_pkg::RESET_CYCLES
) (
  input  wire logic        i_clk_sys,           // system clock
  input  wire logic        i_nrst,              // async reset, active low
  input  wire logic        i_dp,                // bus d+ receive level
  input  wire logic        i_dm,                // bus d- receive level
  input  wire logic [15:0] i_reg_addr,          // register byte address
  input  wire logic        i_reg_wr,            // write strobe
  input  wire logic        i_reg_rd,            // read strobe
  input  wire logic [7:0]  i_reg_wdata,         // write data
  output logic      [7:0]  o_reg_rdata,         // read data, next cycle
  input  wire logic        i_sof_token,         // frame start token seen
  input  wire logic [5:0]  i_in_ep_event,       // in endpoint events
  input  wire logic [5:1]  i_out_ep_event,      // out endpoint events
  input  wire logic        i_addr_applied,      // new address takes effect
  input  wire logic        i_cpu_usb_irq_en,    // global usb irq enable
  input  wire logic        i_fifo_read_little,  // out fifo word order
  input  wire logic        i_fifo_write_little, // in fifo word order
  input  wire logic        i_dma_wr,            // word write toward fifo
  input  wire logic [15:0] i_dma_wdata,         // word from dma
  output logic             o_in_fifo_wr,        // word write to in fifo
  output logic      [15:0] o_in_fifo_data,      // [7:0] goes in first
  input  wire logic        i_out_fifo_valid,    // word read from out fifo
  input  wire logic [15:0] i_out_fifo_data,     // [7:0] came out first
  output logic             o_dma_rvalid,        // word ready for dma
  output logic      [15:0] o_dma_rdata,         // word to dma
  output logic      [6:0]  o_function_address,  // address in effect
  output logic      [3:0]  o_endpoint_index,    // selected endpoint
  output logic             o_usb_reset,         // flush fifos, clear csrs
  output logic             o_iso_wait_sof,      // iso in wait for frame
  output logic             o_drive_resume,      // drive resume upstream
  output logic             o_suspended,         // link in suspend
  output logic             o_wake,              // wake the system
  output logic             o_cpu_usb_irq_set,   // set cpu usb irq flag
  output logic             o_irq_req            // interrupt request
);
  udcc_pkg::udcc_link_t link_state;
  logic [1:0] line;
  logic       line_idle;
  logic       line_se0;
  logic       line_k;
  logic       reset_hit;
  logic       reset_level;
  logic       suspend_hit;
  logic       resume_ev;
  logic [6:0] addr_written;
  logic       addr_pending;
  logic       iso_wait_sof;
  logic       resume_drive;
  logic       susp_status;
  logic       susp_en;
  logic [5:0] in_flags;
  logic [5:1] out_flags;
  logic [3:0] cmn_flags;
  logic [5:0] in_mask;
  logic [5:1] out_mask;
  logic [3:0] cmn_mask;
  logic [3:0] ep_index;
  logic [3:0] cmn_set;
  logic       wr_func;
  logic       wr_power;
  logic       rd_cmn;
  logic       cpu_set;
  logic [7:0] next_rdata;

  if (SUSPEND_CYCLES < 2 || RESET_CYCLES < 1) begin : g_chk
    $error("udcc_common_ctrl: timer counts too small");
  end

  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction : hit

  // filter starts at idle j; a zero start would look like se0 after reset
  udcc_pin_sync #(.W(2), .RST_LEVEL(2'h2)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_async   ({i_dp, i_dm}),
    .o_level   (line)
  );

  assign line_idle = (line == 2'b10);
  assign line_se0  = (line == 2'b00);
  assign line_k    = (line == 2'b01);

  udcc_hold_timer #(.COUNT(RESET_CYCLES)) u_reset_det (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_cond    (line_se0),
    .o_hit     (reset_hit),
    .o_held    (reset_level)
  );

  // idle timing runs only while active, so a suspend is entered once
  udcc_hold_timer #(.COUNT(SUSPEND_CYCLES)) u_idle_det (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_cond    (susp_en && line_idle &&
                link_state == udcc_pkg::LINK_ACTIVE),
    .o_hit     (suspend_hit),
    .o_held    ()
  );

  // se0 is left to the reset detector so a reset never looks like resume
  assign resume_ev = (link_state == udcc_pkg::LINK_SUSPENDED) &&
                     line_k;

  assign wr_func  = i_reg_wr && hit(i_reg_addr, udcc_pkg::ADDR_FUNC);
  assign wr_power = i_reg_wr && hit(i_reg_addr, udcc_pkg::ADDR_POWER);
  assign rd_cmn   = i_reg_rd && hit(i_reg_addr, udcc_pkg::ADDR_CMN_FLAGS);

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      link_state <= udcc_pkg::LINK_ACTIVE;
    end else if (reset_hit || resume_ev) begin
      link_state <= udcc_pkg::LINK_ACTIVE;
    end else if (wr_power && i_reg_wdata[udcc_pkg::PW_RESUME_BIT]) begin
      link_state <= udcc_pkg::LINK_ACTIVE;
    end else if (suspend_hit) begin
      link_state <= udcc_pkg::LINK_SUSPENDED;
    end
  end

  // function address: written value waits for the endpoint logic to apply
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_written       <= '0;
      addr_pending       <= 1'b0;
      o_function_address <= '0;
    end else if (reset_hit) begin
      addr_written       <= '0;
      addr_pending       <= 1'b0;
      o_function_address <= '0;
    end else if (wr_func) begin
      addr_written <= i_reg_wdata[6:0];
      addr_pending <= 1'b1;
    end else if (i_addr_applied && addr_pending) begin
      addr_pending       <= 1'b0;
      o_function_address <= addr_written;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      iso_wait_sof <= 1'b0;
      resume_drive <= 1'b0;
      susp_en      <= 1'b0;
    end else if (wr_power) begin
      iso_wait_sof <= i_reg_wdata[udcc_pkg::PW_ISO_WAIT_BIT];
      resume_drive <= i_reg_wdata[udcc_pkg::PW_RESUME_BIT];
      susp_en      <= i_reg_wdata[udcc_pkg::PW_SUSP_EN_BIT];
    end
  end

  // suspend entry wins over a clearing read in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      susp_status <= 1'b0;
    end else if (suspend_hit) begin
      susp_status <= 1'b1;
    end else if (rd_cmn ||
                 (wr_power && i_reg_wdata[udcc_pkg::PW_RESUME_BIT])) begin
      susp_status <= 1'b0;
    end
  end

  assign cmn_set = {i_sof_token, reset_hit, resume_ev, suspend_hit};

  // read clears, but a same cycle event survives the clear
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      in_flags  <= '0;
      out_flags <= '0;
      cmn_flags <= '0;
    end else begin
      in_flags  <= (i_reg_rd && hit(i_reg_addr, udcc_pkg::ADDR_IN_FLAGS) ?
                    6'h00 : in_flags) | i_in_ep_event;
      out_flags <= (i_reg_rd && hit(i_reg_addr, udcc_pkg::ADDR_OUT_FLAGS) ?
                    5'h00 : out_flags) | i_out_ep_event;
      cmn_flags <= (rd_cmn ? 4'h0 : cmn_flags) |
                   cmn_set;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      in_mask  <= udcc_pkg::IN_MASK_RST;
      out_mask <= udcc_pkg::OUT_MASK_RST[5:1];
      cmn_mask <= udcc_pkg::CMN_MASK_RST;
      ep_index <= '0;
    end else if (reset_hit) begin
      in_mask  <= udcc_pkg::IN_MASK_RST;
      out_mask <= udcc_pkg::OUT_MASK_RST[5:1];
      cmn_mask <= udcc_pkg::CMN_MASK_RST;
      ep_index <= '0;
    end else if (i_reg_wr) begin
      if (hit(i_reg_addr, udcc_pkg::ADDR_IN_MASK)) begin
        in_mask <= i_reg_wdata[5:0];
      end
      if (hit(i_reg_addr, udcc_pkg::ADDR_OUT_MASK)) begin
        out_mask <= i_reg_wdata[5:1];
      end
      if (hit(i_reg_addr, udcc_pkg::ADDR_CMN_MASK)) begin
        cmn_mask <= i_reg_wdata[3:0];
      end
      if (hit(i_reg_addr, udcc_pkg::ADDR_EP_SELECT)) begin
        ep_index <= i_reg_wdata[3:0];
      end
    end
  end

  // reset in suspend goes out on the resume path as well
  assign cpu_set = |(i_in_ep_event & in_mask) |
                   |(i_out_ep_event & out_mask) |
                   |(cmn_set & cmn_mask) |
                   (reset_hit && link_state == udcc_pkg::LINK_SUSPENDED &&
                    cmn_mask[udcc_pkg::CF_RESUME_BIT]);

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cpu_usb_irq_set <= 1'b0;
      o_irq_req         <= 1'b0;
      o_wake            <= 1'b0;
      o_usb_reset       <= 1'b0;
    end else begin
      o_cpu_usb_irq_set <= cpu_set;
      o_irq_req         <= cpu_set && i_cpu_usb_irq_en;
      o_wake            <= resume_ev || (reset_hit &&
                           link_state == udcc_pkg::LINK_SUSPENDED);
      o_usb_reset       <= reset_hit;
    end
  end

  // word order; big endian puts the high byte through the fifo first.
  // no request line toward the dma engine exists on purpose
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_in_fifo_wr   <= 1'b0;
      o_in_fifo_data <= '0;
      o_dma_rvalid   <= 1'b0;
      o_dma_rdata    <= '0;
    end else begin
      o_in_fifo_wr <= i_dma_wr;
      o_dma_rvalid <= i_out_fifo_valid;
      if (i_dma_wr) begin
        o_in_fifo_data <= i_fifo_write_little ? i_dma_wdata :
                          {i_dma_wdata[7:0], i_dma_wdata[15:8]};
      end
      if (i_out_fifo_valid) begin
        o_dma_rdata <= i_fifo_read_little ? i_out_fifo_data :
                       {i_out_fifo_data[7:0],
                        i_out_fifo_data[15:8]};
      end
    end
  end

  // decode; reserved and indexed addresses read zero here
  always_comb begin
    next_rdata = 8'h00;
    if (i_reg_addr >= udcc_pkg::REG_BASE &&
        i_reg_addr < udcc_pkg::REG_RSVD_FIRST) begin
      unique case (i_reg_addr)
        udcc_pkg::ADDR_FUNC:      next_rdata = {addr_pending, addr_written};
        udcc_pkg::ADDR_POWER:     next_rdata = {iso_wait_sof, 3'h0,
                                    reset_level, resume_drive,
                                    susp_status, susp_en};
        udcc_pkg::ADDR_IN_FLAGS:  next_rdata = {2'h0, in_flags};
        udcc_pkg::ADDR_OUT_FLAGS: next_rdata = {2'h0, out_flags, 1'b0};
        udcc_pkg::ADDR_CMN_FLAGS: next_rdata = {4'h0, cmn_flags};
        udcc_pkg::ADDR_IN_MASK:   next_rdata = {2'h0, in_mask};
        udcc_pkg::ADDR_OUT_MASK:  next_rdata = {2'h0, out_mask, 1'b0};
        udcc_pkg::ADDR_CMN_MASK:  next_rdata = {4'h0, cmn_mask};
        udcc_pkg::ADDR_EP_SELECT: next_rdata = {4'h0, ep_index};
        default:                  next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      o_reg_rdata <= next_rdata;
    end
  end

  assign o_endpoint_index = ep_index;
  assign o_iso_wait_sof   = iso_wait_sof;
  assign o_drive_resume   = resume_drive;
  assign o_suspended      = (link_state == udcc_pkg::LINK_SUSPENDED);

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  AST_RESET_ZEROES: assert property (reset_hit |=>
    o_function_address == 7'h00 && ep_index == 4'h0 && o_usb_reset)
    else $error("bus reset did not clear address and index");
  AST_RESET_MASKS: assert property (reset_hit |=>
    in_mask == 6'h3f && out_mask == 5'h1f && cmn_mask == 4'h6)
    else $error("bus reset did not load interrupt enables");
  AST_RESET_FLAG: assert property (reset_hit |=>
    cmn_flags[2] && (o_cpu_usb_irq_set == $past(cmn_mask[2])))
    else $error("bus reset flag or cpu flag wrong");
  AST_SUSPEND_ENTRY: assert property (suspend_hit |=>
    o_suspended && cmn_flags[0] && susp_status)
    else $error("suspend entry not recorded");
  AST_IRQ_GATED: assert property (o_irq_req |->
    o_cpu_usb_irq_set && $past(i_cpu_usb_irq_en))
    else $error("interrupt request without enable");
  AST_EP_MASK: assert property ((|(i_in_ep_event & in_mask)) |=>
    o_cpu_usb_irq_set ##0 (in_flags & $past(i_in_ep_event)) ==
    $past(i_in_ep_event))
    else $error("endpoint event lost");
  AST_RESUME_WAKE: assert property (resume_ev |=>
    cmn_flags[1] && o_wake && !o_suspended)
    else $error("resume not handled");
  AST_RESET_WAKE: assert property (reset_hit && o_suspended |=>
    o_wake && cmn_flags[2] && !o_suspended)
    else $error("reset in suspend did not wake");
  AST_ADDR_APPLY: assert property (wr_func ##1
    (addr_pending && !wr_func && !reset_hit && !i_addr_applied) [*2]
    |=> addr_pending)
    else $error("address pending dropped early");
  AST_ADDR_TAKES: assert property (addr_pending && i_addr_applied &&
    !wr_func && !reset_hit |=> !addr_pending &&
    o_function_address == $past(addr_written))
    else $error("address not applied");
  AST_CLEAR_ON_READ: assert property (rd_cmn && cmn_set == 4'h0 |=>
    cmn_flags == 4'h0)
    else $error("common flags not cleared by read");
  AST_WRITE_ORDER: assert property (i_dma_wr && !i_fifo_write_little |=>
    o_in_fifo_data == {$past(i_dma_wdata[7:0]),
    $past(i_dma_wdata[15:8])})
    else $error("big endian word order wrong");

  COV_SUSPEND: cover property (suspend_hit);
  COV_RESUME: cover property (resume_ev ##1 o_wake);
  COV_RESET_IN_SUSPEND: cover property (reset_hit && o_suspended);
  COV_IRQ: cover property (o_irq_req);
endmodule : udcc_common_ctrl

// ==== src/udcc_hold_timer.sv ====
// Purpose: measures how long a condition has held without a break
// Assumes: i_cond is synchronous
// Notes:   o_hit pulses once per unbroken run, o_held stays while it lasts
`timescale 1ns/1ns
module udcc_hold_timer #(
  parameter int COUNT = 25
) (
  input  wire logic i_clk_sys, // system clock
  input  wire logic i_nrst,    // async reset, active low
  input  wire logic i_cond,    // condition being timed
  output logic      o_hit,     // pulse: run reached COUNT cycles
  output logic      o_held     // level: run has reached COUNT
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LIMIT = CW'(COUNT);
  localparam logic [CW-1:0] LIMIT_M1 = CW'(COUNT - 1);
  logic [CW-1:0] cnt;

  if (COUNT < 1) begin : g_chk
    $error("udcc_hold_timer: COUNT must be at least 1");
  end

  // any break in the condition restarts the run from zero
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= '0;
    end else if (!i_cond) begin
      cnt <= '0;
    end else if (cnt != LIMIT) begin
      cnt <= cnt + CW'(1);
    end
  end

  assign o_hit  = i_cond && (cnt == LIMIT_M1);
  assign o_held = i_cond && (cnt == LIMIT);
endmodule : udcc_hold_timer

// ==== src/udcc_pin_sync.sv ====
// Purpose: three stage synchroniser with agreement filter for bus pins
// Assumes: inputs are asynchronous to i_clk_sys
// Notes:   output moves only once stages two and three agree; all flops
//          start at the idle level so reset release fakes no line change
`timescale 1ns/1ns
module udcc_pin_sync #(
  parameter int             W         = 2,
  parameter logic [W-1:0]   RST_LEVEL = '0
) (
  input  wire logic         i_clk_sys, // system clock
  input  wire logic         i_nrst,    // async reset, active low
  input  wire logic [W-1:0] i_async,   // raw pin levels
  output logic      [W-1:0] o_level    // filtered synchronous levels
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  if (W < 1) begin : g_chk
    $error("udcc_pin_sync: W must be at least 1");
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ff1 <= RST_LEVEL;
      ff2 <= RST_LEVEL;
      ff3 <= RST_LEVEL;
    end else begin
      ff1 <= i_async;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  genvar g;
  for (g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
        o_level[g] <= RST_LEVEL[g];
      end else if (ff2[g] == ff3[g]) begin
        o_level[g] <= ff3[g];
      end
    end
  end
endmodule : udcc_pin_sync

// ==== src/udcc_pkg.sv ====
// Purpose: constants shared by the usb device common control block
// Assumes: 10 MHz system clock, byte wide register strobes
// Notes:   offsets are the byte addresses on the external data space
package udcc_pkg;

  // register window
  localparam logic [15:0] REG_BASE        = 16'hde00;
  localparam logic [15:0] REG_LAST        = 16'hde3f;
  localparam logic [15:0] REG_RSVD_FIRST  = 16'hde2c;
  localparam logic [15:0] ADDR_FUNC       = 16'hde00;
  localparam logic [15:0] ADDR_POWER      = 16'hde01;
  localparam logic [15:0] ADDR_IN_FLAGS   = 16'hde02;
  localparam logic [15:0] ADDR_OUT_FLAGS  = 16'hde04;
  localparam logic [15:0] ADDR_CMN_FLAGS  = 16'hde06;
  localparam logic [15:0] ADDR_IN_MASK    = 16'hde07;
  localparam logic [15:0] ADDR_OUT_MASK   = 16'hde09;
  localparam logic [15:0] ADDR_CMN_MASK   = 16'hde0b;
  localparam logic [15:0] ADDR_EP_SELECT  = 16'hde0e;

  // function_address fields
  localparam int FA_PENDING_BIT = 7;

  // power_control fields
  localparam int PW_ISO_WAIT_BIT = 7;
  localparam int PW_RST_BIT      = 3;
  localparam int PW_RESUME_BIT   = 2;
  localparam int PW_SUSP_BIT     = 1;
  localparam int PW_SUSP_EN_BIT  = 0;

  // common flag and mask fields
  localparam int CF_SOF_BIT    = 3;
  localparam int CF_RST_BIT    = 2;
  localparam int CF_RESUME_BIT = 1;
  localparam int CF_SUSP_BIT   = 0;

  // reset values, also loaded on a bus reset
  localparam logic [5:0] IN_MASK_RST  = 6'h3f;
  localparam logic [5:0] OUT_MASK_RST = 6'h3e;
  localparam logic [3:0] CMN_MASK_RST = 4'h6;

  // timing
  localparam int CLK_PERIOD_NS     = 100;
  localparam int SUSPEND_IDLE_MS   = 3;
  localparam int SUSPEND_CYCLES    =
    (SUSPEND_IDLE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int RESET_MIN_NS      = 2500;
  localparam int RESET_CYCLES      =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [0:0] {
    LINK_ACTIVE    = 1'b0,
    LINK_SUSPENDED = 1'b1
  } udcc_link_t;

endpackage : udcc_pkg
